// *** core/cal_refresh_consts.vh ***
// Constants for the read-calibration pattern path and refresh bookkeeping.
// Assumes a 20 MHz core clock; included by the calibration core design file, not by the FIFO.
`ifndef CAL_REFRESH_CONSTS_VH
`define CAL_REFRESH_CONSTS_VH

// ==========================================
// Mode-register addresses
`define ADDR_TEST_SCRATCH 6'h27
`define ADDR_CAL_FIRST 6'h20
`define ADDR_CAL_SECOND 6'h28
`define ADDR_LANE_INV_LO 6'h0f
`define ADDR_LANE_INV_HI 6'h14
`define ADDR_IO_CONFIG 6'h03

// ==========================================
// Reset values and fields
`define RST_CAL_FIRST 8'h5a
`define RST_CAL_SECOND 8'h3c
`define RST_LANE_INV 8'h00
`define RST_IO_CONFIG 8'h00
`define IO_CFG_RD_INV_BIT 6

// ==========================================
// Refresh timing, ns, and cycle counts at 20 MHz
`define CLK_PERIOD_NS 50
`define T_RFC_AB_NS 380
`define T_RFC_PB_NS 190
`define T_PB2PB_NS 90
// Cycle counts are the ns figures over one clock period, rounded up,
// sized to the monitor's 5-bit counters
`define T_RFC_AB_CYC 5'h08
`define T_RFC_PB_CYC 5'h04
`define T_PB2PB_CYC 5'h02
`define REFRESH_CMDS_PER_WINDOW 8192

`endif

// *** core/cal_fifo.v ***
// Small synchronous FIFO holding calibration beats on their way to the pins.
// Assumes one clock and an asynchronous active-high reset.
module cal_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  reg out_valid_ff;
  wire push;
  wire pop;
  wire load;

  // ==========================================
  // Flags: read data sit in a register, refilled when drained
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = out_valid_ff;
  assign push = in_valid && in_ready;
  assign load = (count_ff != {(AW+1){1'b0}}) && (!out_valid_ff || out_ready);
  assign pop = load;

  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      out_valid_ff <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        out_data <= mem[rd_ptr_ff];
        out_valid_ff <= 1'b1;
      end
      else if (out_ready)
        out_valid_ff <= 1'b0;
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // cal_fifo

// *** core/cal_refresh_core.v ***
// One channel's read-calibration pattern engine and refresh timing monitor.
// Assumes mode-register writes arrive as a decoded address/data strobe and
// the calibration start as a one-cycle pulse, all synchronous to clk.
// Contract
// (R1) Writes to test register 27h are accepted and have no effect.
// (R2) Second pattern resets to 3ch, is updated by writes, write-only.
// (R3) Calibration sends first pattern then second on all DQ and DMI lanes; DMI lanes are driven only with read inversion enabled.
// (R4) Each lane shifts bit 0 first, bit 7 last.
// (R5) Lane inversion applies to DQ lanes only, never to DMI lanes.
// (R6) With read inversion disabled, DMI lanes are not driven during calibration.
// (R7) No data bus inversion is applied to the calibration pattern.
// (R8) Host issues an extra refresh between self-refresh exit and entry.
// (R9) Host issues 8192 refreshes per 32 ms window at 1x rate.
// (R10) Host keeps average refresh spacing 3.904 us all-bank, 488 ns per-bank.
// (R11) Host waits 380 ns after all-bank refresh before using banks.
// (R12) Host waits 190 ns after per-bank refresh before that bank.
// (R13) Host spaces per-bank refreshes to different banks by 90 ns.
// (R14) Channel refresh state is independent of the other channel.
// (R15) Host extends window only when refresh-rate status allows it.
// (R16) Host waits per-bank cycle time plus 17.5 ns after self-refresh abort.
// (R17) Host picks refresh rate from case rating or die sensor.
// (R18) First pattern resets to 5ah and leads the calibration stream.
// (R19) A readout after a pattern write uses the new value at once.
`include "cal_refresh_consts.vh"

module cal_refresh_core #(
  parameter FIFO_DEPTH = 8
) (
  input wire clk,
  input wire reset,
  input wire mrw_valid,
  input wire [5:0] mrw_addr,
  input wire [7:0] mrw_data,
  input wire cal_start,
  input wire refresh_ab,
  input wire refresh_pb,
  input wire [2:0] refresh_bank,
  input wire bank_cmd,
  input wire [2:0] bank_cmd_bank,
  output wire cal_busy,
  output reg [15:0] dq_out,
  output reg [15:0] dq_oe,
  output reg [1:0] dmi_out,
  output reg [1:0] dmi_oe,
  output reg timing_violation_ff,
  output reg [15:0] refresh_count_ff
);
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  reg [7:0] cal_first_ff;
  reg [7:0] cal_second_ff;
  reg [7:0] lane_inv_lo_ff;
  reg [7:0] lane_inv_hi_ff;
  reg [7:0] io_config_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [3:0] bit_idx_ff;
  reg [15:0] pattern_ff;
  reg [4:0] ab_busy_ff;
  reg [4:0] pb_busy_ff [0:7];
  reg [4:0] pb2pb_ff;
  reg [2:0] last_pb_bank_ff;
  wire [15:0] lane_inv;
  wire cur_bit;
  wire push_ready;
  wire push_valid;
  wire [17:0] push_data;
  wire pop_valid;
  wire [17:0] pop_data;
  wire dmi_enable;
  integer i;

  // Sixteen lanes, each picks its own inversion bit
  function [15:0] lane_word;
    input b;
    input [15:0] inv;
    begin
      lane_word = {16{b}} ^ inv;
    end
  endfunction

  // ==========================================
  // Mode registers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cal_first_ff <= `RST_CAL_FIRST; // R18
      cal_second_ff <= `RST_CAL_SECOND; // R2
      lane_inv_lo_ff <= `RST_LANE_INV;
      lane_inv_hi_ff <= `RST_LANE_INV;
      io_config_ff <= `RST_IO_CONFIG;
    end
    else if (mrw_valid)
    begin
      case (mrw_addr)
        `ADDR_CAL_FIRST: cal_first_ff <= mrw_data;
        `ADDR_CAL_SECOND: cal_second_ff <= mrw_data; // R2
        `ADDR_LANE_INV_LO: lane_inv_lo_ff <= mrw_data;
        `ADDR_LANE_INV_HI: lane_inv_hi_ff <= mrw_data;
        `ADDR_IO_CONFIG: io_config_ff <= mrw_data;
        `ADDR_TEST_SCRATCH: ; // R1
        default: ;
      endcase
    end
  end

  // ==========================================
  // Calibration sequencer
  // Pattern is captured on start, so a write in the same cycle still lands
  // through the bypass below rather than the stale register.
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (cal_start) nxt_state = ST_SEND;
      ST_SEND: if (push_ready && bit_idx_ff == 4'hf) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      bit_idx_ff <= 4'h0;
      pattern_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && cal_start)
      begin
        bit_idx_ff <= 4'h0;
        pattern_ff <= {(mrw_valid && mrw_addr == `ADDR_CAL_SECOND) ? mrw_data : cal_second_ff,
                       (mrw_valid && mrw_addr == `ADDR_CAL_FIRST) ? mrw_data : cal_first_ff}; // R19 R3
      end
      else if (state_ff == ST_SEND && push_ready)
        bit_idx_ff <= bit_idx_ff + 4'h1;
    end
  end

  assign cal_busy = (state_ff == ST_SEND);
  assign lane_inv = {lane_inv_hi_ff, lane_inv_lo_ff};
  assign cur_bit = pattern_ff[bit_idx_ff]; // R4
  assign push_valid = cal_busy;
  // DMI carries the raw bit; DQ gets per-lane inversion and no DBI
  assign push_data = {cur_bit, cur_bit, lane_word(cur_bit, lane_inv)}; // R5 R7
  assign dmi_enable = io_config_ff[`IO_CFG_RD_INV_BIT];

  cal_fifo #(
    .WIDTH(18),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(1'b1),
    .out_data(pop_data)
  );

  // ==========================================
  // Pin drivers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dq_out <= 16'h0000;
      dq_oe <= 16'h0000;
      dmi_out <= 2'h0;
      dmi_oe <= 2'h0;
    end
    else
    begin
      dq_out <= pop_valid ? pop_data[15:0] : 16'h0000; // R3
      dq_oe <= {16{pop_valid}};
      dmi_out <= (pop_valid && dmi_enable) ? pop_data[17:16] : 2'h0; // R5
      dmi_oe <= {2{pop_valid && dmi_enable}}; // R6
    end
  end

  // ==========================================
  // Refresh monitor: flags host timing slips, purely per channel
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ab_busy_ff <= 5'h00;
      pb2pb_ff <= 5'h00;
      last_pb_bank_ff <= 3'h0;
      timing_violation_ff <= 1'b0;
      refresh_count_ff <= 16'h0000; // R14
      for (i = 0; i < 8; i = i + 1)
        pb_busy_ff[i] <= 5'h00;
    end
    else
    begin
      if (ab_busy_ff != 5'h00)
        ab_busy_ff <= ab_busy_ff - 5'h01;
      if (pb2pb_ff != 5'h00)
        pb2pb_ff <= pb2pb_ff - 5'h01;
      for (i = 0; i < 8; i = i + 1)
        if (pb_busy_ff[i] != 5'h00)
          pb_busy_ff[i] <= pb_busy_ff[i] - 5'h01;
      // Counters load one short: a command on the edge where the window closes is legal
      if (refresh_ab)
      begin
        ab_busy_ff <= `T_RFC_AB_CYC - 5'h01; // R11
        refresh_count_ff <= refresh_count_ff + 16'h0001;
      end
      if (refresh_pb)
      begin
        pb_busy_ff[refresh_bank] <= `T_RFC_PB_CYC - 5'h01; // R12
        pb2pb_ff <= `T_PB2PB_CYC - 5'h01; // R13
        last_pb_bank_ff <= refresh_bank;
        refresh_count_ff <= refresh_count_ff + 16'h0001;
      end
      // Sticky until reset: a slip is a host bug, not a runtime event
      if ((bank_cmd && (ab_busy_ff != 5'h00 || pb_busy_ff[bank_cmd_bank] != 5'h00)) ||
          (refresh_pb && pb2pb_ff != 5'h00 && refresh_bank != last_pb_bank_ff))
        timing_violation_ff <= 1'b1;
    end
  end
endmodule // cal_refresh_core

// *** tb/cal_refresh_core_properties.sv ***
// Checker on the pins of the calibration and refresh core.
// Bound to cal_refresh_core; sees its ports only.
module cal_refresh_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic cal_start,
  input wire logic refresh_ab,
  input wire logic refresh_pb,
  input wire logic bank_cmd,
  input wire logic cal_busy,
  input wire logic [15:0] dq_oe,
  input wire logic [1:0] dmi_out,
  input wire logic [1:0] dmi_oe,
  input wire logic timing_violation_ff,
  input wire logic [15:0] refresh_count_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic rf = refresh_ab || refresh_pb;
  // ========
  // Sequences
  sequence s_go; cal_start && !cal_busy; endsequence
  sequence s_on; (dq_oe == 16'hffff)[*8] ##1 (dq_oe == 16'hffff)[*8]; endsequence
  sequence s_early; refresh_ab ##7 bank_cmd; endsequence
  sequence s_ab_ok; refresh_ab ##8 (bank_cmd && !timing_violation_ff); endsequence
  sequence s_pb_ok; refresh_pb ##4 (bank_cmd && !timing_violation_ff); endsequence
  sequence s_pp_ok; refresh_pb ##2 (refresh_pb && !timing_violation_ff); endsequence
  // ========
  // Properties
  property p_busy; s_go |=> cal_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_burst; s_go |-> ##4 s_on; endproperty
  a_burst: assert property (p_burst) else $error("burst shape");
  property p_dmi_gate; dmi_oe != 2'h0 |-> dq_oe == 16'hffff; endproperty
  a_dmi_gate: assert property (p_dmi_gate) else $error("mask lanes stray");
  property p_dmi_raw; dmi_oe == 2'h3 |-> dmi_out[0] == dmi_out[1]; endproperty
  a_dmi_raw: assert property (p_dmi_raw) else $error("mask lanes differ");
  property p_cnt_inc; rf |=> refresh_count_ff == $past(refresh_count_ff) + 16'h1; endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("count step");
  property p_cnt_hold; !rf |=> $stable(refresh_count_ff); endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("count moved");
  property p_sticky; timing_violation_ff |=> timing_violation_ff; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_early; s_early |-> ##[1:3] timing_violation_ff; endproperty
  a_early: assert property (p_early) else $error("early use unflagged");
  property p_ab_ok; s_ab_ok |=> !timing_violation_ff; endproperty
  a_ab_ok: assert property (p_ab_ok) else $error("legal all-bank use flagged");
  property p_pb_ok; s_pb_ok |=> !timing_violation_ff; endproperty
  a_pb_ok: assert property (p_pb_ok) else $error("legal per-bank use flagged");
  property p_pp_ok; s_pp_ok |=> !timing_violation_ff; endproperty
  a_pp_ok: assert property (p_pp_ok) else $error("legal refresh pair flagged");
endmodule // cal_refresh_checker
bind cal_refresh_core cal_refresh_checker cal_refresh_checker_i (.clk, .reset, .cal_start, .refresh_ab,
  .refresh_pb, .bank_cmd, .cal_busy, .dq_oe, .dmi_out, .dmi_oe, .timing_violation_ff, .refresh_count_ff);

// *** tb/cal_host_model.sv ***
// Host controller model: mode writes, calibration starts, refreshes.
// Assumes the bench calls its tasks; pins change at the falling edge.
module cal_host_model (
  input wire logic clk,
  output logic mrw_valid,
  output logic [5:0] mrw_addr,
  output logic [7:0] mrw_data,
  output logic cal_start,
  output logic refresh_ab,
  output logic refresh_pb,
  output logic [2:0] refresh_bank,
  output logic bank_cmd,
  output logic [2:0] bank_cmd_bank
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {mrw_valid, mrw_addr, mrw_data, cal_start, refresh_ab, refresh_pb, refresh_bank} = '0;
  // Never enters or aborts self-refresh and stays at the 1x window
  initial {bank_cmd, bank_cmd_bank} = '0;
  // ========
  // Commands
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    {mrw_valid, mrw_addr, mrw_data} = {1'b1, a, d};
    @(negedge clk);
    mrw_valid = 1'b0;
  endtask
  task automatic go();
    @(negedge clk);
    cal_start = 1'b1;
    @(negedge clk);
    cal_start = 1'b0;
  endtask
  // Two per-bank refreshes to different banks, two cycles apart
  task automatic pair(input logic [2:0] b0, input logic [2:0] b1);
    @(negedge clk);
    {refresh_pb, refresh_bank} = {1'b1, b0};
    @(negedge clk);
    refresh_pb = 1'b0;
    @(negedge clk);
    {refresh_pb, refresh_bank} = {1'b1, b1};
    @(negedge clk);
    refresh_pb = 1'b0;
  endtask
  // Uses the bank w+1 cycles after the refresh; w+1 below the cycle time is a fault
  task automatic refr(input logic ab, input logic [2:0] b, input int w);
    @(negedge clk);
    {refresh_ab, refresh_pb, refresh_bank} = {ab, !ab, b};
    @(negedge clk);
    {refresh_ab, refresh_pb} = 2'h0;
    repeat (w) @(negedge clk);
    {bank_cmd, bank_cmd_bank} = {1'b1, b};
    @(negedge clk);
    bank_cmd = 1'b0;
  endtask
endmodule // cal_host_model

// *** tb/cal_refresh_core_tb_top.sv ***
// Bench for cal_refresh_core with a host model and inline expected values.
// Assumes a 50 ns clock; stimulus comes through the host model.
module cal_refresh_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  wire mrw_valid, cal_start, refresh_ab, refresh_pb, bank_cmd, cal_busy, timing_violation_ff;
  wire [5:0] mrw_addr;
  wire [7:0] mrw_data;
  wire [2:0] refresh_bank, bank_cmd_bank;
  wire [15:0] dq_out, dq_oe, refresh_count_ff;
  wire [1:0] dmi_out, dmi_oe;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int refs = 0;
  logic [7:0] pat [2] = '{8'h5a, 8'h3c};
  logic [5:0] adr [5] = '{6'h20, 6'h28, 6'h0f, 6'h14, 6'h03};
  logic [15:0] inv = 16'h0;
  logic dmi_on = 1'b0;
  initial forever #25 clk = ~clk;
  cal_host_model cal_host_model_i (.clk, .mrw_valid, .mrw_addr, .mrw_data, .cal_start, .refresh_ab,
    .refresh_pb, .refresh_bank, .bank_cmd, .bank_cmd_bank);
  cal_refresh_core cal_refresh_core_i (.clk, .reset, .mrw_valid, .mrw_addr, .mrw_data, .cal_start,
    .refresh_ab, .refresh_pb, .refresh_bank, .bank_cmd, .bank_cmd_bank, .cal_busy, .dq_out, .dq_oe,
    .dmi_out, .dmi_oe, .timing_violation_ff, .refresh_count_ff);
  // ========
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Mode 1: a second start during the burst must be ignored
  // Mode 2: the second pattern is written in the start cycle itself
  task automatic burst(input int mode);
    logic b;
    if (mode == 2)
      fork
        cal_host_model_i.mrw(6'h28, pat[1]);
        cal_host_model_i.go();
      join
    else
      cal_host_model_i.go();
    if (mode == 1)
      cal_host_model_i.go();
    for (int i = 0; i < 6 && dq_oe[0] !== 1'b1; i++)
      @(negedge clk);
    for (int k = 0; k < 16; k++)
    begin
      b = pat[k / 8][k % 8];
      check(dq_oe, 16'hffff);
      check(dq_out, {16{b}} ^ inv);
      check({12'h0, dmi_oe, dmi_out}, {12'h0, {2{dmi_on}}, {2{dmi_on & b}}});
      @(negedge clk);
    end
    check(dq_oe, 16'h0);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      final_report();
    end
  end
  // ========
  // Tests
  initial
  begin
    logic [7:0] r [5];
    void'($urandom(27));
    repeat (8) @(negedge clk);
    reset = 1'b0;
    burst(0);
    $display("test defaults done");
    cal_host_model_i.mrw(6'h27, 8'($urandom));
    burst(1);
    $display("test ignored write done");
    for (int n = 0; n < 4; n++)
    begin
      foreach (r[j])
        r[j] = 8'($urandom);
      r[4][6] = n[1];
      pat = '{r[0], r[1]};
      inv = {r[3], r[2]};
      dmi_on = r[4][6];
      foreach (r[j])
        cal_host_model_i.mrw(adr[j], r[j]);
      burst(n[0]);
    end
    $display("test patterns done");
    pat[1] = 8'($urandom);
    burst(2);
    $display("test same-cycle write done");
    @(negedge clk);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    pat = '{8'h5a, 8'h3c};
    inv = 16'h0;
    dmi_on = 1'b0;
    burst(0);
    $display("test mid-run reset done");
    for (int j = 0; j < 5; j++)
    begin
      // Bank use lands exactly on the cycle-time boundary, which is legal
      cal_host_model_i.refr(j == 0, 3'(j), (j == 0) ? 7 : 3);
      refs++;
    end
    cal_host_model_i.pair(3'h5, 3'h6);
    refs += 2;
    check(refresh_count_ff, 16'(refs));
    check({15'h0, timing_violation_ff}, 16'h0);
    // One cycle short of the all-bank cycle time
    cal_host_model_i.refr(1'b1, 3'h2, 6);
    refs++;
    for (int i = 0; i < 4 && timing_violation_ff !== 1'b1; i++)
      @(negedge clk);
    check({15'h0, timing_violation_ff}, 16'h1);
    check(refresh_count_ff, 16'(refs));
    $display("test refresh done");
    final_report();
  end
endmodule // cal_refresh_core_tb_top
